// ===== dwt_pkg.sv
// Package for the divider, watchdog and dual timer unit.
// Assumes a single clock domain with synchronous active-high reset.
package dwt_pkg;

  localparam int DIV_W       = 14;
  localparam int DIV_CLR_LO  = 10;   // lowest stage cleared by divider clear
  localparam int WD_W        = 4;
  localparam int TM_W        = 8;
  localparam int NIB_W       = 4;

  localparam int PRE_T0_FAST = 4;
  localparam int PRE_T0_SLOW = 1024;
  localparam int PRE_T1_SLOW = 64;
  localparam int PRE_WD_FAST = 1024;
  localparam int PRE_WD_SLOW = 16384;
  localparam int PRE_W       = 14;

  // Field positions.
  localparam int RATE_BIT    = 3;    // watchdog rate select
  localparam int T0_CLK_BIT  = 0;
  localparam int T1_DIV_BIT  = 0;
  localparam int T1_EXT_BIT  = 1;
  localparam int T1_TONE_BIT = 2;
  localparam int RUN_BIT     = 3;
  localparam int EV_DIV      = 0;
  localparam int EV_T0       = 1;
  localparam int EV_T1       = 7;

  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] TM_UFL   = 8'hff;

  typedef enum logic [2:0] {
    DWT_OP_NONE,
    DWT_OP_LOAD_LO,
    DWT_OP_LOAD_HI,
    DWT_OP_LOAD_IMM,
    DWT_OP_CTRL
  } dwt_op_e;

  typedef struct packed {
    logic [13:0] div;
    logic [13:0] pre;       // shared prescaler for timers and watchdog
    logic [3:0]  wd;
    logic [3:0]  rate;
    logic [3:0]  t0_ctrl;
    logic [3:0]  t1_ctrl;
    logic [7:0]  t0;
    logic [7:0]  t1;
    logic [7:0]  t1_reload;
    logic [7:0]  flags;
    logic        ext_q;
    logic        tone;
    logic        chip_rst;
  } dwt_state_s;

endpackage

// ===== dwt_timer_unit.sv
// Timing unit: periodic divider, watchdog and two 8-bit down-counting timers.
// Assumes the core issues one-cycle instruction strobes synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - 14-bit divider counts up on every clock from reset.
// - Divider overflow sets event bit 0; gated by interrupt and hold enables.
// - Divider clear resets only the top four divider stages.
// - 4-bit watchdog counts up; overflow pulses a chip reset.
// - Watchdog works only when its option input is 1.
// - Watchdog clock is osc/1024, or osc/16384 when rate bit 3 set.
// - Watchdog clear zeroes the watchdog counter.
// - Rate register changes only through set-bits and clear-bits masks.
// - Timer 0 is 8-bit down counter, nibble or immediate loadable.
// - Timer 0 nibble load stops it, clears run bit, loads nibble.
// - Setting timer 0 run bit clears event bit 1 and starts counting.
// - Timer 0 stops at FFH, sets event bit 1, gated requests.
// - Timer 0 clock select bit 0: osc/4 when 0, osc/1024 when 1.
// - Timer 0 interval is (preset+1) times the prescale.
// - Timer 1 counts osc, osc/64 or external pin; osc after reset.
// - External source decrements timer 1 on each pin falling edge.
// - Timer 1 nibble load writes reload buffer and clears run bit.
// - Setting timer 1 run copies buffer to counter, clears event bit 7.
// - Timer 1 immediate load reloads both, clears flag, sets run.
// - Timer 1 ticking at 00H sets event bit 7, reloads, keeps counting.
// - Tone pin toggles on each timer 1 underflow when routed.
// - Control bit 1 picks external pin, bit 0 picks osc/64.
// - Tone pin carries waveform input when control bit 2 is 0.
module dwt_timer_unit (
  input  wire logic       clk_i,          // system oscillator clock
  input  wire logic       srst_i,         // synchronous reset, active high
  input  wire logic       wd_option_i,    // watchdog option bit
  input  wire logic       div_clr_i,      // divider clear strobe
  input  wire logic       wd_clr_i,       // watchdog clear strobe
  input  wire logic       rate_set_i,     // rate register set-bits strobe
  input  wire logic       rate_clr_i,     // rate register clear-bits strobe
  input  wire logic [3:0] rate_mask_i,    // immediate mask for rate register
  input  wire logic [2:0] t0_op_i,        // timer 0 operation (dwt_op_e)
  input  wire logic [2:0] t1_op_i,        // timer 1 operation (dwt_op_e)
  input  wire logic [7:0] load_data_i,    // nibble in [3:0] or immediate byte
  input  wire logic [7:0] flag_clr_i,     // event flag clear strobes per bit
  input  wire logic [7:0] int_enable_i,   // interrupt enable flags
  input  wire logic [7:0] hold_enable_i,  // hold-release enable flags
  input  wire logic       ext_count_i,    // external count pin
  input  wire logic       wave_i,         // waveform generator output
  output logic      [7:0] event_flags_o,  // sticky event flags
  output logic            irq_o,          // interrupt request level
  output logic            hold_release_o, // hold release level
  output logic            chip_reset_o,   // watchdog reset pulse
  output logic            tone_o,         // tone output pin
  output logic      [7:0] t0_count_o,     // timer 0 counter
  output logic      [7:0] t1_count_o      // timer 1 counter
);

  ////////////////////////////////////////////////////////////////////////////

  localparam logic [13:0] T0_FAST_M = 14'(dwt_pkg::PRE_T0_FAST - 1);
  localparam logic [13:0] T0_SLOW_M = 14'(dwt_pkg::PRE_T0_SLOW - 1);
  localparam logic [13:0] T1_SLOW_M = 14'(dwt_pkg::PRE_T1_SLOW - 1);
  localparam logic [13:0] WD_FAST_M = 14'(dwt_pkg::PRE_WD_FAST - 1);
  localparam logic [13:0] WD_SLOW_M = 14'(dwt_pkg::PRE_WD_SLOW - 1);
  localparam logic [13:0] DIV_LO_M  = 14'((1 << dwt_pkg::DIV_CLR_LO) - 1);

  dwt_pkg::dwt_state_s s_q, s_d;
  dwt_pkg::dwt_op_e    op0, op1;

  logic [13:0] pre_nx;
  logic        t0_tick, t1_tick, wd_tick, ext_fall, div_ovf;
  logic        t0_run, t1_run, t1_ufl;
  logic [7:0]  set_ev;

  assign op0 = dwt_pkg::dwt_op_e'(t0_op_i);
  assign op1 = dwt_pkg::dwt_op_e'(t1_op_i);

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d    = s_q;
    set_ev = dwt_pkg::FLAG_RST;
    t1_ufl = 1'b0;

    // One free-running prescaler serves all tap points; a tap fires when the
    // low bits of the current value are all ones, so rates stay exact.
    pre_nx   = s_q.pre + 14'h0001;
    s_d.pre  = pre_nx;
    t0_tick  = s_q.t0_ctrl[dwt_pkg::T0_CLK_BIT] ? ((s_q.pre & T0_SLOW_M) == T0_SLOW_M)
                                               : ((s_q.pre & T0_FAST_M) == T0_FAST_M);
    ext_fall = s_q.ext_q & ~ext_count_i;
    if (s_q.t1_ctrl[dwt_pkg::T1_EXT_BIT]) begin
      t1_tick = ext_fall;
    end else if (s_q.t1_ctrl[dwt_pkg::T1_DIV_BIT]) begin
      t1_tick = (s_q.pre & T1_SLOW_M) == T1_SLOW_M;
    end else begin
      t1_tick = 1'b1;
    end
    wd_tick  = s_q.rate[dwt_pkg::RATE_BIT] ? ((s_q.pre & WD_SLOW_M) == WD_SLOW_M)
                                          : ((s_q.pre & WD_FAST_M) == WD_FAST_M);
    s_d.ext_q = ext_count_i;

    // Divider.
    div_ovf = &s_q.div;
    s_d.div = s_q.div + 14'h0001;
    if (div_ovf) begin
      set_ev[dwt_pkg::EV_DIV] = 1'b1;
    end
    if (div_clr_i) begin
      s_d.div = s_d.div & DIV_LO_M;
    end

    // Watchdog.
    s_d.chip_rst = 1'b0;
    if (!wd_option_i) begin
      s_d.wd = 4'h0;
    end else if (wd_clr_i) begin
      s_d.wd = 4'h0;
    end else if (wd_tick) begin
      s_d.wd = s_q.wd + 4'h1;
      s_d.chip_rst = &s_q.wd;
    end
    if (rate_set_i) begin
      s_d.rate = s_d.rate | rate_mask_i;
    end
    if (rate_clr_i) begin
      s_d.rate = s_d.rate & ~rate_mask_i;
    end

    // Timer 0.
    t0_run = s_q.t0_ctrl[dwt_pkg::RUN_BIT];
    if (t0_run && t0_tick) begin
      s_d.t0 = s_q.t0 - 8'h01;
      if (s_q.t0 == 8'h00) begin
        s_d.t0_ctrl[dwt_pkg::RUN_BIT] = 1'b0;
        set_ev[dwt_pkg::EV_T0]        = 1'b1;
      end
    end
    case (op0)
      dwt_pkg::DWT_OP_LOAD_LO: begin
        s_d.t0[3:0] = load_data_i[3:0];
        s_d.t0_ctrl[dwt_pkg::RUN_BIT] = 1'b0;
      end
      dwt_pkg::DWT_OP_LOAD_HI: begin
        s_d.t0[7:4] = load_data_i[3:0];
        s_d.t0_ctrl[dwt_pkg::RUN_BIT] = 1'b0;
      end
      dwt_pkg::DWT_OP_LOAD_IMM: begin
        s_d.t0 = load_data_i;
      end
      dwt_pkg::DWT_OP_CTRL: begin
        s_d.t0_ctrl = load_data_i[3:0];
        if (load_data_i[dwt_pkg::RUN_BIT]) begin
          s_d.t0 = s_q.t0;
          s_d.flags[dwt_pkg::EV_T0] = 1'b0;
          set_ev[dwt_pkg::EV_T0] = 1'b0;
        end
      end
      default: ;
    endcase

    // Timer 1.
    t1_run = s_q.t1_ctrl[dwt_pkg::RUN_BIT];
    if (t1_run && t1_tick) begin
      if (s_q.t1 == 8'h00) begin
        s_d.t1 = s_q.t1_reload;
        t1_ufl = 1'b1;
        set_ev[dwt_pkg::EV_T1] = 1'b1;
        s_d.tone = ~s_q.tone;
      end else begin
        s_d.t1 = s_q.t1 - 8'h01;
      end
    end
    case (op1)
      dwt_pkg::DWT_OP_LOAD_LO: begin
        s_d.t1_reload[3:0] = load_data_i[3:0];
        s_d.t1_ctrl[dwt_pkg::RUN_BIT] = 1'b0;
        s_d.t1 = s_q.t1;
      end
      dwt_pkg::DWT_OP_LOAD_HI: begin
        s_d.t1_reload[7:4] = load_data_i[3:0];
        s_d.t1_ctrl[dwt_pkg::RUN_BIT] = 1'b0;
        s_d.t1 = s_q.t1;
      end
      dwt_pkg::DWT_OP_LOAD_IMM: begin
        s_d.t1_reload = load_data_i;
        s_d.t1 = load_data_i;
        s_d.t1_ctrl[dwt_pkg::RUN_BIT] = 1'b1;
        s_d.flags[dwt_pkg::EV_T1] = 1'b0;
        set_ev[dwt_pkg::EV_T1] = 1'b0;
      end
      dwt_pkg::DWT_OP_CTRL: begin
        s_d.t1_ctrl = load_data_i[3:0];
        if (load_data_i[dwt_pkg::RUN_BIT]) begin
          s_d.t1 = s_q.t1_reload;
          s_d.flags[dwt_pkg::EV_T1] = 1'b0;
          set_ev[dwt_pkg::EV_T1] = 1'b0;
        end
      end
      default: ;
    endcase

    // Explicit clear loses against a simultaneous event.
    s_d.flags = (s_d.flags & ~flag_clr_i) | set_ev;

    if (srst_i) begin
      s_d = '0;
      s_d.rate    = dwt_pkg::CTRL_RST;
      s_d.t0_ctrl = dwt_pkg::CTRL_RST;
      s_d.t1_ctrl = dwt_pkg::CTRL_RST;
      s_d.flags   = dwt_pkg::FLAG_RST;
      s_d.ext_q   = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////

  assign event_flags_o  = s_q.flags;
  assign irq_o          = |(s_q.flags & int_enable_i);
  assign hold_release_o = |(s_q.flags & hold_enable_i);
  assign chip_reset_o   = s_q.chip_rst;
  assign tone_o         = s_q.t1_ctrl[dwt_pkg::T1_TONE_BIT] ? s_q.tone : wave_i;
  assign t0_count_o     = s_q.t0;
  assign t1_count_o     = s_q.t1;

endmodule

`default_nettype wire

// ===== dwt_properties.sv
// Port-level properties of the timing unit.
// Assumes it is bound into dwt_timer_unit.
`timescale 1ns/1ps
`default_nettype none
module dwt_properties (
  input wire logic       clk_i,         // clock
  input wire logic       srst_i,        // reset
  input wire logic       wd_option_i,   // wd on
  input wire logic [7:0] flag_clr_i,    // clears
  input wire logic [7:0] int_enable_i,  // enables
  input wire logic [2:0] t0_op_i,       // t0 op
  input wire logic [2:0] t1_op_i,       // t1 op
  input wire logic [7:0] load_data_i,   // operand
  input wire logic [7:0] event_flags_o, // flags
  input wire logic       irq_o,         // irq
  input wire logic       chip_reset_o,  // wd reset
  input wire logic [7:0] t0_count_o,    // t0
  input wire logic [7:0] t1_count_o     // t1
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  sequence s_t1_imm;
    t1_op_i == 3'h3;
  endsequence
  property p_t1_imm;
    s_t1_imm |=> t1_count_o == $past(load_data_i) && !event_flags_o[7];
  endproperty
  a_t1_imm: assert property (p_t1_imm) else $error("t1 load");
  property p_t0_lo;
    t0_op_i == 3'h1 |=> t0_count_o[3:0] == $past(load_data_i[3:0]);
  endproperty
  a_t0_lo: assert property (p_t0_lo) else $error("t0 low");
  property p_t0_hi;
    t0_op_i == 3'h2 |=> t0_count_o[7:4] == $past(load_data_i[3:0]);
  endproperty
  a_t0_hi: assert property (p_t0_hi) else $error("t0 high");
  property p_t1_ufl;
    $rose(event_flags_o[7]) |-> $past(t1_count_o) == 8'h00;
  endproperty
  a_t1_ufl: assert property (p_t1_ufl) else $error("t1 flag");
  property p_t0_ufl;
    $rose(event_flags_o[1]) && t0_op_i == 3'h0 |-> t0_count_o == 8'hff ##1 t0_count_o == 8'hff;
  endproperty
  a_t0_ufl: assert property (p_t0_ufl) else $error("t0 stop");
  property p_irq;
    irq_o == |(event_flags_o & int_enable_i);
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_wd_off;
    !wd_option_i ##1 !wd_option_i |-> !chip_reset_o;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("wd off");
  property p_flag_hold;
    event_flags_o[7] && !flag_clr_i[7] && t1_op_i == 3'h0 |=> event_flags_o[7];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
endmodule
`default_nettype wire

// ===== dwt_core_model.sv
// Core model: one-cycle timer instructions and periodic watchdog clears.
// Assumes callers start each task one small delay after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module dwt_core_model (
  input  wire logic       clk_i,   // clock
  input  wire logic       kick_i,  // auto clear on
  output logic      [2:0] t0_op_o, // t0 op
  output logic      [2:0] t1_op_o, // t1 op
  output logic      [7:0] data_o,  // operand
  output logic            wd_clr_o // wd clear
);
  int kick_n;
  initial begin
    t0_op_o = 3'h0;
    t1_op_o = 3'h0;
    data_o = 8'h00;
    wd_clr_o = 1'b0;
    kick_n = 0;
  end
  // Half the fast watchdog tick leaves margin for the prescaler phase.
  always @(posedge clk_i) begin
    #1;
    kick_n = (kick_n + 1) % 512;
    wd_clr_o = kick_i && kick_n == 0;
  end
  // An instruction stays on the lines after its edge so that a following one
  // replaces it in one step; the caller ends a run of them with idle.
  task automatic issue(input logic [2:0] a, input logic [2:0] b, input logic [7:0] d);
    t0_op_o = a;
    t1_op_o = b;
    data_o = d;
    @(posedge clk_i);
    #1;
  endtask
  task automatic idle;
    t0_op_o = 3'h0;
    t1_op_o = 3'h0;
  endtask
endmodule
`default_nettype wire

// ===== dwt_timer_unit_bench.sv
// Bench for the timing unit with the core model on the instruction side.
// Assumes the checker and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dwt_timer_unit_bench;
  logic       clk_i, srst_i, wd_option_i, div_clr_i, rate_set_i, rate_clr_i, ext_count_i;
  logic       wave_i, kick, wd_kick, wd_auto, irq_o, hold_o, rst_o, tone_o;
  logic [2:0] t0_op, t1_op;
  logic [3:0] rate_mask;
  logic [7:0] data, flag_clr, int_en, hold_en, flags, t0_q, t1_q;
  int         mismatches = 0, n_tests = 0, n_rst = 0;
  dwt_core_model u_dwt_core_model (.clk_i, .kick_i(kick), .t0_op_o(t0_op), .t1_op_o(t1_op),
    .data_o(data), .wd_clr_o(wd_auto));
  dwt_timer_unit u_dwt_timer_unit (.clk_i, .srst_i, .wd_option_i, .div_clr_i,
    .wd_clr_i(wd_auto | wd_kick), .rate_set_i, .rate_clr_i, .rate_mask_i(rate_mask),
    .t0_op_i(t0_op), .t1_op_i(t1_op), .load_data_i(data), .flag_clr_i(flag_clr),
    .int_enable_i(int_en), .hold_enable_i(hold_en), .ext_count_i, .wave_i,
    .event_flags_o(flags), .irq_o, .hold_release_o(hold_o), .chip_reset_o(rst_o), .tone_o,
    .t0_count_o(t0_q), .t1_count_o(t1_q));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (rst_o === 1'b1) n_rst++;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_flag(input int b, input int lo, input int hi);
    cyc(lo);
    chk("flag early", flags[b], 1'b0);
    cyc(hi - lo);
    chk("flag late", flags[b], 1'b1);
  endtask
  task automatic pulse_clr(input logic [7:0] m);
    flag_clr = m;
    cyc(1);
    flag_clr = 8'h00;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_timer1;
    chk("tone idle", tone_o, 1'b1);
    u_dwt_core_model.issue(3'h0, 3'h4, 8'h04);
    u_dwt_core_model.issue(3'h0, 3'h3, 8'h02);
    u_dwt_core_model.idle;
    chk("t1 load", t1_q, 8'h02);
    cyc(3);
    chk("t1 reload", {flags[7], t1_q}, 9'h102);
    chk("tone", {tone_o, irq_o}, 2'h3);
    pulse_clr(8'h80);
    chk("t1 clear", {flags[7], t1_q}, 9'h001);
    wave_i = 1'b0;
    u_dwt_core_model.issue(3'h0, 3'h1, 8'h05);
    u_dwt_core_model.issue(3'h0, 3'h4, 8'h08);
    u_dwt_core_model.idle;
    chk("t1 run", {flags[7], tone_o, t1_q}, 10'h005);
  endtask
  task automatic t_ext;
    u_dwt_core_model.issue(3'h0, 3'h4, 8'h0a);
    u_dwt_core_model.idle;
    repeat (2) begin
      ext_count_i = 1'b1;
      cyc(3);
      ext_count_i = 1'b0;
      cyc(3);
    end
    chk("t1 ext", t1_q, 8'h03);
    u_dwt_core_model.issue(3'h0, 3'h4, 8'h09);
    u_dwt_core_model.idle;
    cyc(128);
    chk("t1 div64", t1_q, 8'h03);
  endtask
  task automatic t_timer0;
    u_dwt_core_model.issue(3'h1, 3'h0, 8'h02);
    u_dwt_core_model.issue(3'h2, 3'h0, 8'h00);
    chk("t0 load", t0_q, 8'h02);
    u_dwt_core_model.issue(3'h4, 3'h0, 8'h08);
    u_dwt_core_model.idle;
    wait_flag(1, 7, 13);
    chk("t0 stop", t0_q, 8'hff);
    u_dwt_core_model.issue(3'h4, 3'h0, 8'h08);
    chk("t0 start", flags[1], 1'b0);
    u_dwt_core_model.issue(3'h1, 3'h0, 8'h01);
    u_dwt_core_model.issue(3'h2, 3'h0, 8'h00);
    u_dwt_core_model.issue(3'h4, 3'h0, 8'h09);
    u_dwt_core_model.idle;
    wait_flag(1, 1024, 2050);
  endtask
  task automatic t_div;
    int n;
    n = 0;
    while (flags[0] !== 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    chk("hold", hold_o, 1'b1);
    pulse_clr(8'h01);
    wait_flag(0, 16380, 16386);
    pulse_clr(8'h01);
    cyc(7990);
    div_clr_i = 1'b1;
    cyc(1);
    div_clr_i = 1'b0;
    wait_flag(0, 15550, 15562);
    chk("wd off", n_rst, 0);
  endtask
  task automatic t_wd;
    wd_option_i = 1'b1;
    rate_mask = 4'h8;
    rate_set_i = 1'b1;
    wd_kick = 1'b1;
    cyc(1);
    rate_set_i = 1'b0;
    wd_kick = 1'b0;
    cyc(17500);
    chk("wd slow", n_rst, 0);
    rate_clr_i = 1'b1;
    wd_kick = 1'b1;
    cyc(1);
    rate_clr_i = 1'b0;
    wd_kick = 1'b0;
    cyc(15300);
    chk("wd early", n_rst, 0);
    cyc(2200);
    chk("wd fire", n_rst, 1);
  endtask
  // The limit sits above the longest path through all scenarios.
  initial begin
    #(40 * 100000);
    mismatches++;
    wrap_up;
  end
  initial begin
    {srst_i, wd_option_i, div_clr_i, rate_set_i, rate_clr_i, ext_count_i} = 6'h20;
    {kick, wd_kick, wave_i, rate_mask, flag_clr} = 15'h1000;
    int_en = 8'h82;
    hold_en = 8'h01;
    cyc(4);
    srst_i = 1'b0;
    t_timer1;
    t_ext;
    t_timer0;
    t_div;
    t_wd;
    wrap_up;
  end
endmodule
bind dwt_timer_unit dwt_properties u_dwt_properties (.clk_i, .srst_i, .wd_option_i,
  .flag_clr_i, .int_enable_i, .t0_op_i, .t1_op_i, .load_data_i, .event_flags_o, .irq_o,
  .chip_reset_o, .t0_count_o, .t1_count_o);
`default_nettype wire
